/* logic/hot_swap_params.svh */
// Offsets, bit positions, reset values and constants of the hot-swap register set
`ifndef HOT_SWAP_PARAMS_SVH
`define HOT_SWAP_PARAMS_SVH

// ****************************************************
// Register offsets (byte addresses in config space)
// ****************************************************
`define HS_CAP_ID_OFFSET 8'he4
`define HS_NEXT_PTR_OFFSET 8'he5
`define HS_CTRL_STAT_OFFSET 8'he6

// ****************************************************
// Fixed read values and reset values
// ****************************************************
`define HS_CAP_ID_VALUE 8'h06
`define HS_NEXT_PTR_VALUE 8'h00
`define HS_PROG_IFACE_VALUE 2'h1
`define HS_FLAG_RESET 1'h0

// ****************************************************
// Bit positions within the 32-bit dword, and the byte lane of the control/status bits
// ****************************************************
`define HS_HIDE_ARM_BIT 16
`define HS_ENUM_MASK_BIT 17
`define HS_PENDING_BIT 18
`define HS_LAMP_BIT 19
`define HS_PROG_IFACE_LSB 20
`define HS_EXTRACT_BIT 22
`define HS_INSERT_BIT 23
`define HS_CTRL_BYTE_LANE 2

`endif

/* logic/hot_swap_pkg.sv */
// Types shared by the hot-swap register set
package hot_swap_pkg;

  // Hot-swap sequence states
  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_WAIT_CLOSE,
    ST_INSERT,
    ST_ACTIVE,
    ST_EXTRACT
  } hs_state_t;

  // Configuration access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  // Stored control and status bits
  typedef struct packed {
    logic hide_arm_bit;
    logic enum_output_mask;
    logic indicator_lamp_ctrl;
    logic extraction_flag;
    logic insertion_flag;
  } hs_csr_t;

endpackage : hot_swap_pkg

/* logic/hot_swap_control_regs.sv */
// Hot-swap capability registers, sequence and pin outputs of the bridge
`include "hot_swap_params.svh"

module hot_swap_control_regs (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire hot_swap_pkg::cfg_req_t cfg_req,
  input wire logic handle_closed,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  output logic enumeration_out_n,
  output logic lamp_on,
  output logic device_hidden
);
  import hot_swap_pkg::*;

  // ****************************************************
  // Declarations
  // ****************************************************
  hs_state_t state;
  hs_state_t next_state;
  hs_csr_t csr;
  hs_csr_t next_csr;
  logic [31:0] next_rdata;
  logic next_ack;
  logic next_enum_n;
  logic [7:0] cap_offset;
  logic hit;
  logic accepted;
  logic ctrl_write;
  logic [31:0] wd;
  logic hw_hide_set;
  logic hw_hide_clear;
  logic ins_event;
  logic ext_event;
  logic [31:0] cap_dword;

  // ****************************************************
  // Access decode
  // ****************************************************
  // Base of the capability dword; only the dword part of the address is compared,
  // so any byte address inside the dword selects it
  assign cap_offset = `HS_CAP_ID_OFFSET;
  assign hit = cfg_req.addr[7:2] == cap_offset[7:2];

  // Hidden device ignores every access, reads and writes alike
  assign accepted = cfg_req.valid && !csr.hide_arm_bit;

  // Only the control/status lane holds writable bits; the two lower bytes
  // are constants and the upper byte is reserved, so their lanes are ignored
  assign ctrl_write = accepted && cfg_req.write && hit && cfg_req.be[`HS_CTRL_BYTE_LANE];

  // Write data seen by the field updates
  assign wd = cfg_req.wdata;

  // ****************************************************
  // Hot-swap sequence
  // ****************************************************
  // Handle is looked at only after reset release, never during it
  assign hw_hide_set = (state == ST_POWERUP) && !handle_closed;

  // Leaving the hidden state needs a full insertion pass through INSERT
  assign hw_hide_clear = (state == ST_INSERT);

  // Insertion is reported once per pass through INSERT
  assign ins_event = (state == ST_INSERT);

  // Extraction is reported while an active board sees its handle open;
  // the state moves on at the same edge, so the event lasts one cycle
  assign ext_event = (state == ST_ACTIVE) && !handle_closed;

  // Next state of the sequence
  always_comb begin
    next_state = state;
    case (state)
      ST_POWERUP: begin
        next_state = handle_closed ? ST_INSERT : ST_WAIT_CLOSE;
      end
      ST_WAIT_CLOSE: begin
        if (handle_closed) begin
          next_state = ST_INSERT;
        end
      end
      ST_INSERT: begin
        next_state = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (!handle_closed) begin
          next_state = ST_EXTRACT;
        end
      end
      ST_EXTRACT: begin
        if (handle_closed) begin
          next_state = ST_INSERT;
        end
      end
      default: begin
        next_state = ST_POWERUP;
      end
    endcase
  end

  // ****************************************************
  // Control and status bits
  // ****************************************************
  // Hardware set and clear win over a software write in the same cycle.
  // A flag raised in the cycle of its own W1C stays set, so no event is lost;
  // software then sees it on the next read and clears it again.
  always_comb begin
    next_csr = csr;
    if (ctrl_write) begin
      next_csr.hide_arm_bit = wd[`HS_HIDE_ARM_BIT];
      next_csr.enum_output_mask = wd[`HS_ENUM_MASK_BIT];
      next_csr.indicator_lamp_ctrl = wd[`HS_LAMP_BIT];
      if (wd[`HS_EXTRACT_BIT]) begin
        next_csr.extraction_flag = 1'h0;
      end
      if (wd[`HS_INSERT_BIT]) begin
        next_csr.insertion_flag = 1'h0;
      end
    end
    if (hw_hide_set) begin
      next_csr.hide_arm_bit = 1'h1;
    end
    if (hw_hide_clear) begin
      next_csr.hide_arm_bit = 1'h0;
    end
    if (ext_event) begin
      next_csr.extraction_flag = 1'h1;
    end
    if (ins_event) begin
      next_csr.insertion_flag = 1'h1;
    end
  end

  // ****************************************************
  // Read data and outputs
  // ****************************************************
  // Dword image of the capability entry; the upper byte is reserved and reads zero
  assign cap_dword = {
    8'h00,
    csr.insertion_flag,
    csr.extraction_flag,
    `HS_PROG_IFACE_VALUE,
    csr.indicator_lamp_ctrl,
    1'h0,
    csr.enum_output_mask,
    csr.hide_arm_bit,
    `HS_NEXT_PTR_VALUE,
    `HS_CAP_ID_VALUE
  };

  // Answer only accepted accesses; other dwords read zero
  always_comb begin
    next_ack = accepted;
    next_rdata = 32'h0000_0000;
    if (accepted && !cfg_req.write && hit) begin
      next_rdata = cap_dword;
    end
  end

  // Pin is low while an unmasked flag is set.
  // It is computed from the next bit values so the pin moves on the same
  // edge as the stored bits, which keeps the register image and pin in step.
  always_comb begin
    next_enum_n = 1'h1;
    if (!next_csr.enum_output_mask) begin
      next_enum_n = !(next_csr.extraction_flag || next_csr.insertion_flag);
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  // Sequence and stored bits
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_POWERUP;
      csr <= '0;
    end else begin
      state <= next_state;
      csr <= next_csr;
    end
  end

  // Registered bus answer and pins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_ack <= 1'h0;
      cfg_rdata <= 32'h0000_0000;
      enumeration_out_n <= 1'h1;
      lamp_on <= 1'h0;
      device_hidden <= 1'h0;
    end else begin
      cfg_ack <= next_ack;
      cfg_rdata <= next_rdata;
      enumeration_out_n <= next_enum_n;
      lamp_on <= next_csr.indicator_lamp_ctrl;
      device_hidden <= next_csr.hide_arm_bit;
    end
  end

endmodule // hot_swap_control_regs

/* sim/ejector_switch.sv */
// Ejector handle switch model
module ejector_switch (
  input logic ref_clk,
  input logic lever,
  output logic handle_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contact moves just after a rising edge
  always @(posedge ref_clk) handle_closed <= lever;
endmodule // ejector_switch

/* sim/hot_swap_control_regs_chk.sv */
// Port checks of the hot-swap register set
module hot_swap_control_regs_chk (
  input logic ref_clk, arst_n, handle_closed, cfg_ack,
  input logic enumeration_out_n, lamp_on, device_hidden,
  input hot_swap_pkg::cfg_req_t cfg_req,
  input logic [31:0] cfg_rdata
);
  import hot_swap_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Accepted request decode
  wire acc = cfg_req.valid && !device_hidden && cfg_req.addr[7:2] == 6'h39;
  wire wr = acc && cfg_req.write && cfg_req.be[2];
  sequence s_settled; handle_closed [*3]; endsequence
  sequence s_clear; wr && cfg_req.wdata[23:22] == 2'h3; endsequence
  property p_ack; cfg_req.valid && !device_hidden |=> cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no answer");
  property p_hide; cfg_req.valid && device_hidden |=> !cfg_ack; endproperty
  a_hide: assert property (p_hide) else $error("hidden answer");
  property p_id; acc && !cfg_req.write |=> (cfg_rdata & 32'hff34ffff) == 32'h00100006;
  endproperty
  a_id: assert property (p_id) else $error("fixed fields");
  property p_lamp; wr |=> lamp_on == $past(cfg_req.wdata[19]); endproperty
  a_lamp: assert property (p_lamp) else $error("lamp");
  property p_mask; cfg_ack && cfg_rdata[17] |-> enumeration_out_n; endproperty
  a_mask: assert property (p_mask) else $error("masked pin low");
  property p_flag; cfg_ack && !cfg_rdata[17] && |cfg_rdata[23:22] |-> !enumeration_out_n;
  endproperty
  a_flag: assert property (p_flag) else $error("pin high");
  property p_open; !$past(arst_n) && !handle_closed |=> device_hidden; endproperty
  a_open: assert property (p_open) else $error("hide not set");
  property p_closed; !$past(arst_n) && handle_closed |=> ##1 !enumeration_out_n && !device_hidden;
  endproperty
  a_closed: assert property (p_closed) else $error("no insertion");
  property p_clear; s_settled ##0 s_clear |=> enumeration_out_n; endproperty
  a_clear: assert property (p_clear) else $error("pin stays low");
endmodule // hot_swap_control_regs_chk

/* sim/test_hot_swap_control_regs.sv */
// Self-checking bench of the hot-swap register set
module test_hot_swap_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import hot_swap_pkg::*;
  logic ref_clk = 0, arst_n = 0, lever = 1, handle_closed, k;
  logic cfg_ack, enumeration_out_n, lamp_on, device_hidden;
  logic [31:0] cfg_rdata, q;
  cfg_req_t cfg_req = '0;
  int miscompares = 0, checked = 0, cycles = 0;
  hot_swap_control_regs dut (.ref_clk(ref_clk), .arst_n(arst_n), .cfg_req(cfg_req),
    .handle_closed(handle_closed), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .enumeration_out_n(enumeration_out_n), .lamp_on(lamp_on), .device_hidden(device_hidden));
  ejector_switch sw (.ref_clk(ref_clk), .lever(lever), .handle_closed(handle_closed));
  initial forever #12.5 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) if (++cycles == 3000) begin
    miscompares++;
    print_verdict();
  end
  task print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One request, answer taken one cycle later
  task acc(input logic w, input logic [3:0] be, input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    cfg_req = '{1'b1, w, a, be, d};
    @(negedge ref_clk);
    k = cfg_ack;
    q = cfg_rdata;
    cfg_req.valid = 1'b0;
  endtask
  task rd(input logic [31:0] e);
    acc(1'b0, 4'h0, 8'he6, 32'h0);
    chk("ack", 32'h1, {31'h0, k});
    chk("rdata", e, q);
  endtask
  task wr(input logic [31:0] d);
    acc(1'b1, 4'hf, 8'he4, d);
  endtask
  task pins(input logic [2:0] e);
    chk("pins", {29'h0, e}, {29'h0, enumeration_out_n, lamp_on, device_hidden});
  endtask
  task settle(input int n, input logic v);
    lever = v;
    repeat (n) @(negedge ref_clk);
  endtask
  task rst(input logic v);
    arst_n = 0;
    settle(8, v);
    arst_n = 1;
    repeat (3) @(negedge ref_clk);
  endtask
  task t_closed();
    rst(1);
    pins(3'b000);
    rd(32'h00900006);
    wr(32'h00c00000);
    rd(32'h00100006);
    pins(3'b100);
    acc(1'b0, 4'h0, 8'he0, 32'h0);
    chk("unmapped ack", 32'h1, {31'h0, k});
    chk("unmapped", 32'h0, q);
    $display("test closed done");
  endtask
  task t_regs();
    wr(32'hff3effff);
    rd(32'h001a0006);
    pins(3'b110);
    acc(1'b1, 4'hb, 8'he4, 32'h0);
    rd(32'h001a0006);
    settle(3, 0);
    pins(3'b110);
    rd(32'h005a0006);
    wr(32'h0);
    pins(3'b000);
    settle(4, 1);
    rd(32'h00d00006);
    wr(32'h00c00000);
    pins(3'b100);
    $display("test regs done");
  endtask
  task t_hide();
    wr(32'h00010000);
    pins(3'b101);
    acc(1'b0, 4'h0, 8'he6, 32'h0);
    chk("refused", 32'h0, {31'h0, k});
    settle(3, 0);
    settle(4, 1);
    pins(3'b000);
    rd(32'h00d00006);
    $display("test hide done");
  endtask
  task t_open();
    rst(0);
    pins(3'b101);
    settle(4, 1);
    pins(3'b000);
    rd(32'h00900006);
    $display("test open done");
  endtask
  initial begin
    t_closed();
    t_regs();
    t_hide();
    t_open();
    print_verdict();
  end
endmodule // test_hot_swap_control_regs
bind hot_swap_control_regs hot_swap_control_regs_chk u_chk (.ref_clk(ref_clk),
  .arst_n(arst_n), .handle_closed(handle_closed), .cfg_ack(cfg_ack), .cfg_req(cfg_req),
  .enumeration_out_n(enumeration_out_n), .lamp_on(lamp_on),
  .device_hidden(device_hidden), .cfg_rdata(cfg_rdata));
